// ===== hw/acirq_bank.sv
/*
 ADC per-channel control and status bank: early interrupt enables and
 flags, sign and differential selection, channel interrupt enables,
 result-ready flags and a common interrupt, behind classic Wishbone.
 Assumes the conversion cores pulse conv_start once per conversion,
 core_tick once per core clock period, and result_write when the
 result lands in the channel result buffer.
*/
// The address map and the Wishbone slave port were chosen for this implementation.
// Behaviour
// - Each channel has an early-interrupt enable; zero suppresses its early interrupt.
// - Early-interrupt flag sets when an early interrupt is produced for the channel.
// - Reading the channel result buffer clears its early-interrupt flag.
// - Each channel has a sign-select bit choosing signed or unsigned output.
// - Channels 0 and 1 have differential bits at bits 1 and 3.
// - Channel interrupt enable gates both common and individual interrupts.
// - Read-only ready flag is high while a result waits in the buffer.
// - Enable and status high-half registers hold channels 16 to 20 in bits 4:0, rest zero; input mode control 0 high holds channels 8 to 15.
// - All implemented bits reset to zero.
// - Sign bits 16 to 19 at even bits 0 to 6, channel 20 at bit 8.
// - Early interrupt fires 1 to 8 core periods, code plus one, before ready.
`timescale 1ns/1ns
module acirq_bank
    import acirq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Conversion cores
    input wire acirq_core_events_type core_events,
    input wire logic [NUM_CH-1:0] result_buffer_read,
    input wire logic [7:0] conv_length,
    // Channel side outputs
    output acirq_channel_mode_type channel_mode,
    output logic [NUM_CH-1:0] individual_irq,
    output logic [NUM_CH-1:0] early_irq,
    output logic common_irq,
    output logic irq
);
    logic [NUM_CH-1:0] early_irq_en;
    logic [NUM_CH-1:0] early_irq_flag;
    logic [NUM_CH-1:0] signed_output_sel;
    logic [1:0] differential_sel;
    logic [NUM_CH-1:0] channel_irq_en;
    logic [NUM_CH-1:0] result_ready_flag;
    logic [LEAD_SEL_W-1:0] early_irq_lead_sel;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_enable;
    logic [7:0] periods_left [NUM_CH];
    logic [NUM_CH-1:0] converting;
    logic [NUM_CH-1:0] early_hit;
    acirq_bus_state_type bus_state;
    logic [31:0] next_rdata;
    logic bus_req;
    logic wr_stb;

    // Even-bit spread of 8 sign bits into a 16-bit word
    function automatic logic [15:0] spread_even(input logic [7:0] v);
        logic [15:0] r;
        r = RESET_REG;
        for (int i = 0; i < 8; i++) begin
            r[2*i] = v[i];
        end
        return r;
    endfunction

    function automatic logic [7:0] gather_even(input logic [15:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = w[2*i];
        end
        return r;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && (bus_state == ACIRQ_IDLE);
    assign wr_stb = bus_req && wb_we_i && clk_en;

    // Bus handshake: one wait cycle, ack for one cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_state <= ACIRQ_IDLE;
            wb_ack_o <= 1'b0;
        end else if (clk_en) begin
            case (bus_state)
                ACIRQ_IDLE: begin
                    wb_ack_o <= bus_req;
                    if (bus_req) begin
                        bus_state <= ACIRQ_ACK;
                    end
                end
                ACIRQ_ACK: begin
                    wb_ack_o <= 1'b0;
                    bus_state <= ACIRQ_IDLE;
                end
                default: begin
                    wb_ack_o <= 1'b0;
                    bus_state <= ACIRQ_IDLE;
                end
            endcase
        end
    end

    // Read mux; unused high bits read zero
    always_comb begin
        next_rdata = RESET_WORD;
        case (wb_adr_i)
            OFF_EARLY_IRQ_ENABLE_LOW: next_rdata[15:0] = early_irq_en[15:0];
            OFF_EARLY_IRQ_ENABLE_HIGH: next_rdata[4:0] = early_irq_en[20:16];
            OFF_EARLY_IRQ_STATUS_LOW: next_rdata[15:0] = early_irq_flag[15:0];
            OFF_EARLY_IRQ_STATUS_HIGH: next_rdata[4:0] = early_irq_flag[20:16];
            OFF_INPUT_MODE_CTRL0_LOW: begin
                next_rdata[15:0] = spread_even(signed_output_sel[7:0]);
                next_rdata[DIFF0_BIT] = differential_sel[0];
                next_rdata[DIFF1_BIT] = differential_sel[1];
            end
            OFF_INPUT_MODE_CTRL0_HIGH:
                next_rdata[15:0] = spread_even(signed_output_sel[15:8]);
            OFF_INPUT_MODE_CTRL1_LOW:
                next_rdata[15:0] = spread_even({3'h0, signed_output_sel[20:16]});
            OFF_CHANNEL_IRQ_ENABLE_LOW: next_rdata[15:0] = channel_irq_en[15:0];
            OFF_CHANNEL_IRQ_ENABLE_HIGH: next_rdata[4:0] = channel_irq_en[20:16];
            OFF_RESULT_READY_STATUS_LOW: next_rdata[15:0] = result_ready_flag[15:0];
            OFF_RESULT_READY_STATUS_HIGH: next_rdata[4:0] = result_ready_flag[20:16];
            OFF_EARLY_LEAD_SEL: next_rdata[LEAD_SEL_W-1:0] = early_irq_lead_sel;
            OFF_EVENT_STATUS: next_rdata[EVT_W-1:0] = evt_status;
            OFF_EVENT_ENABLE: next_rdata[EVT_W-1:0] = evt_enable;
            default: next_rdata = RESET_WORD;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_dat_o <= RESET_WORD;
        end else if (clk_en) begin
            wb_dat_o <= bus_req && !wb_we_i ? next_rdata : RESET_WORD;
        end
    end

    // Enable registers; unimplemented bits are simply not stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            early_irq_en <= '0;
            channel_irq_en <= '0;
        end else if (wr_stb) begin
            if (hit(wb_adr_i, OFF_EARLY_IRQ_ENABLE_LOW)) begin
                early_irq_en[15:0] <= merge16(early_irq_en[15:0], wb_dat_i, wb_sel_i);
            end
            if (hit(wb_adr_i, OFF_EARLY_IRQ_ENABLE_HIGH) && wb_sel_i[0]) begin
                early_irq_en[20:16] <= wb_dat_i[4:0];
            end
            if (hit(wb_adr_i, OFF_CHANNEL_IRQ_ENABLE_LOW)) begin
                channel_irq_en[15:0] <= merge16(channel_irq_en[15:0], wb_dat_i, wb_sel_i);
            end
            if (hit(wb_adr_i, OFF_CHANNEL_IRQ_ENABLE_HIGH) && wb_sel_i[0]) begin
                channel_irq_en[20:16] <= wb_dat_i[4:0];
            end
        end
    end

    // Sign and differential selects; odd positions other than the two differential bits are not stored, so read zero
    always_ff @(posedge ref_clk) begin
        logic [15:0] w;
        w = RESET_REG;
        if (srst) begin
            signed_output_sel <= '0;
            differential_sel <= 2'b00;
        end else if (wr_stb) begin
            if (hit(wb_adr_i, OFF_INPUT_MODE_CTRL0_LOW)) begin
                w = merge16(spread_even(signed_output_sel[7:0]), wb_dat_i, wb_sel_i);
                signed_output_sel[7:0] <= gather_even(w);
                if (wb_sel_i[0]) begin
                    differential_sel <= {wb_dat_i[DIFF1_BIT], wb_dat_i[DIFF0_BIT]};
                end
            end
            if (hit(wb_adr_i, OFF_INPUT_MODE_CTRL0_HIGH)) begin
                w = merge16(spread_even(signed_output_sel[15:8]), wb_dat_i, wb_sel_i);
                signed_output_sel[15:8] <= gather_even(w);
            end
            if (hit(wb_adr_i, OFF_INPUT_MODE_CTRL1_LOW)) begin
                w = merge16(spread_even({3'h0, signed_output_sel[20:16]}), wb_dat_i, wb_sel_i);
                signed_output_sel[20:16] <= 5'(gather_even(w));
            end
        end
    end

    // Lead select and event enable live in the low byte lane only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            early_irq_lead_sel <= RESET_LEAD_SEL;
            evt_enable <= RESET_EVT;
        end else if (wr_stb && wb_sel_i[0]) begin
            if (hit(wb_adr_i, OFF_EARLY_LEAD_SEL)) begin
                early_irq_lead_sel <= wb_dat_i[LEAD_SEL_W-1:0];
            end
            if (hit(wb_adr_i, OFF_EVENT_ENABLE)) begin
                evt_enable <= wb_dat_i[EVT_W-1:0];
            end
        end
    end

    // Per-channel conversion countdown in core clock periods
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        // Periods still to run after this tick set the lead
        // A conversion shorter than the lead plus one never raises an early interrupt
        assign early_hit[c] = converting[c] && core_events.core_tick[c]
            && (periods_left[c] - 8'h01 == {5'h00, early_irq_lead_sel} + 8'(LEAD_MIN_PERIODS))
            && early_irq_en[c];

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                periods_left[c] <= 8'h00;
                converting[c] <= 1'b0;
            end else if (clk_en) begin
                if (core_events.conv_start[c]) begin
                    periods_left[c] <= conv_length;
                    converting[c] <= 1'b1;
                end else if (core_events.result_write[c]) begin
                    converting[c] <= 1'b0;
                end else if (converting[c] && core_events.core_tick[c]
                             && periods_left[c] != 8'h00) begin
                    periods_left[c] <= periods_left[c] - 8'h01;
                end
            end
        end

        // Set wins over the buffer-read clear
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                early_irq_flag[c] <= 1'b0;
            end else if (clk_en) begin
                if (early_hit[c]) begin
                    early_irq_flag[c] <= 1'b1;
                end else if (result_buffer_read[c]) begin
                    early_irq_flag[c] <= 1'b0;
                end
            end
        end

        // Hardware owned; a new result beats a simultaneous read
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                result_ready_flag[c] <= 1'b0;
            end else if (clk_en) begin
                if (core_events.result_write[c]) begin
                    result_ready_flag[c] <= 1'b1;
                end else if (result_buffer_read[c]) begin
                    result_ready_flag[c] <= 1'b0;
                end
            end
        end
    end

    // Channel mode towards the cores, registered
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            channel_mode <= '0;
        end else if (clk_en) begin
            channel_mode.signed_output_sel <= signed_output_sel;
            channel_mode.differential_sel <= differential_sel;
        end
    end

    // Per-channel interrupts, one cycle behind the ready flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            individual_irq <= '0;
        end else if (clk_en) begin
            individual_irq <= result_ready_flag & channel_irq_en;
        end
    end

    // Early pulses, one cycle behind the countdown match
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            early_irq <= '0;
        end else if (clk_en) begin
            early_irq <= early_hit;
        end
    end

    // Common interrupt from any enabled ready channel
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            common_irq <= 1'b0;
        end else if (clk_en) begin
            common_irq <= |(result_ready_flag & channel_irq_en);
        end
    end

    // Sticky event bits, write-one-to-clear; set wins
    always_ff @(posedge ref_clk) begin
        logic [EVT_W-1:0] set_bits;
        logic [EVT_W-1:0] clr_bits;
        set_bits = {|(result_ready_flag & channel_irq_en), |early_hit};
        clr_bits = (wr_stb && hit(wb_adr_i, OFF_EVENT_CLEAR) && wb_sel_i[0])
            ? wb_dat_i[EVT_W-1:0] : RESET_EVT;
        if (srst) begin
            evt_status <= RESET_EVT;
        end else if (clk_en) begin
            evt_status <= (evt_status & ~clr_bits) | set_bits;
        end
    end

    // Level interrupt from enabled sticky bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(evt_status & evt_enable);
        end
    end
endmodule

// ===== hw/acirq_pkg.sv
/*
 Package for the ADC channel interrupt and status bank: register
 offsets, field layout, reset values and timing constants.
 Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
package acirq_pkg;
    localparam int NUM_CH = 21;
    localparam int NUM_CH_LOW = 16;
    localparam int NUM_CH_HIGH = 5;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;

    // Byte offsets, one aligned word each
    localparam logic [7:0] OFF_EARLY_IRQ_ENABLE_LOW = 8'h00;
    localparam logic [7:0] OFF_EARLY_IRQ_ENABLE_HIGH = 8'h04;
    localparam logic [7:0] OFF_EARLY_IRQ_STATUS_LOW = 8'h08;
    localparam logic [7:0] OFF_EARLY_IRQ_STATUS_HIGH = 8'h0c;
    localparam logic [7:0] OFF_INPUT_MODE_CTRL0_LOW = 8'h10;
    localparam logic [7:0] OFF_INPUT_MODE_CTRL0_HIGH = 8'h14;
    localparam logic [7:0] OFF_INPUT_MODE_CTRL1_LOW = 8'h18;
    localparam logic [7:0] OFF_CHANNEL_IRQ_ENABLE_LOW = 8'h1c;
    localparam logic [7:0] OFF_CHANNEL_IRQ_ENABLE_HIGH = 8'h20;
    localparam logic [7:0] OFF_RESULT_READY_STATUS_LOW = 8'h24;
    localparam logic [7:0] OFF_RESULT_READY_STATUS_HIGH = 8'h28;
    localparam logic [7:0] OFF_EARLY_LEAD_SEL = 8'h2c;
    localparam logic [7:0] OFF_EVENT_STATUS = 8'h30;
    localparam logic [7:0] OFF_EVENT_CLEAR = 8'h34;
    localparam logic [7:0] OFF_EVENT_ENABLE = 8'h38;

    // Field positions
    localparam int DIFF0_BIT = 1;
    localparam int DIFF1_BIT = 3;
    localparam int LEAD_SEL_W = 3;
    localparam int EVT_EARLY_BIT = 0;
    localparam int EVT_READY_BIT = 1;
    localparam int EVT_W = 2;

    // Reset values
    localparam logic [15:0] RESET_REG = 16'h0000;
    localparam logic [2:0] RESET_LEAD_SEL = 3'h0;
    localparam logic [1:0] RESET_EVT = 2'h0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Early lead: code + 1 core clock periods before data ready
    localparam int LEAD_MIN_PERIODS = 1;

    typedef enum logic [1:0] {
        ACIRQ_IDLE = 2'b00,
        ACIRQ_ACK = 2'b01
    } acirq_bus_state_type;

    // Per-channel event input from the conversion cores
    typedef struct packed {
        logic [NUM_CH-1:0] result_write;
        logic [NUM_CH-1:0] core_tick;
        logic [NUM_CH-1:0] conv_start;
    } acirq_core_events_type;

    // Per-channel configuration towards the cores
    typedef struct packed {
        logic [NUM_CH-1:0] signed_output_sel;
        logic [1:0] differential_sel;
    } acirq_channel_mode_type;
endpackage

// ===== dv/acirq_bank_chk.sv
/*
 Checker for the ADC channel control and status bank, bound to its top.
 Assumes one clock, a synchronous reset and clk_en held high.
*/
`timescale 1ns/1ns
module acirq_bank_chk
    import acirq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Channel side
    input wire acirq_core_events_type core_events,
    input wire logic [NUM_CH-1:0] result_buffer_read,
    input wire acirq_channel_mode_type channel_mode,
    input wire logic [NUM_CH-1:0] individual_irq,
    input wire logic [NUM_CH-1:0] early_irq,
    input wire logic common_irq,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    ack_delay_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("bus ack not one cycle after request");
    rdata_idle_a: assert property ((!wb_ack_o || wb_we_i) |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside read ack");
    reset_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        srst |=> !irq && !common_irq && individual_irq == '0 && channel_mode == '0)
        else $error("outputs not cleared by reset");
    irq_any_a: assert property (common_irq == (|individual_irq))
        else $error("common interrupt differs from channel interrupts");
    early_tick_a: assert property ((early_irq & ~$past(core_events.core_tick)) == '0)
        else $error("early interrupt without a core tick");
    early_pulse_a: assert property ((early_irq & $past(early_irq)) == '0)
        else $error("early interrupt longer than one cycle");
    ready_clear_a: assert property (
        |(result_buffer_read & ~core_events.result_write) |-> ##2
        (individual_irq & $past(result_buffer_read & ~core_events.result_write, 2)) == '0)
        else $error("channel interrupt stays after buffer read");
    mode_write_a: assert property ($changed(channel_mode) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("channel mode changed without a write");
endmodule

bind acirq_bank acirq_bank_chk chk (.ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_ack_o, .wb_dat_o, .core_events, .result_buffer_read, .channel_mode,
    .individual_irq, .early_irq, .common_irq, .irq);

// ===== dv/acirq_core_model.sv
/*
 Conversion core model: one conversion at a time, ticks paced by pace.
 Assumes the bench asks for a conversion only while busy is low.
*/
`timescale 1ns/1ns
module acirq_core_model
    import acirq_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Command
    input wire logic start,
    input wire logic [4:0] ch,
    input wire logic [1:0] pace,
    input wire logic [7:0] conv_length,
    // Towards the bank
    output acirq_core_events_type core_events,
    output logic busy,
    output logic [7:0] ticks
);
    logic [4:0] cur = 5'h00;
    logic [1:0] gap = 2'h0;
    initial core_events = '0;
    initial busy = 1'b0;
    initial ticks = 8'h00;
    // Result lands with the last tick; a slow pace leaves idle cycles between ticks
    always @(posedge ref_clk) begin
        acirq_core_events_type nxt;
        nxt = '0;
        if (start && !busy) begin
            nxt.conv_start[ch] = 1'b1;
            cur <= ch;
            busy <= 1'b1;
            ticks <= 8'h00;
            gap <= 2'h0;
        end else if (busy) begin
            gap <= (gap == pace) ? 2'h0 : gap + 2'h1;
            if (gap == pace) begin
                ticks <= ticks + 8'h01;
                nxt.core_tick[cur] = 1'b1;
                if (ticks + 8'h01 == conv_length) begin
                    nxt.result_write[cur] = 1'b1;
                    busy <= 1'b0;
                end
            end
        end
        core_events <= nxt;
    end
endmodule

// ===== dv/tb_acirq_bank.sv
/*
 Self-checking bench for the ADC channel control and status bank.
 Assumes consecutive register offsets from 0x00 and conv_length of 10.
*/
`timescale 1ns/1ns
module tb_acirq_bank;
    import acirq_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [NUM_CH-1:0] rbr = '0;
    logic start = 1'b0;
    logic [4:0] ch = 5'h00;
    logic [1:0] pace = 2'h1;
    acirq_core_events_type ev;
    acirq_channel_mode_type mode;
    logic [31:0] rdat;
    logic ack, common_irq, irq, busy;
    logic [NUM_CH-1:0] ind, early;
    logic [7:0] ticks;
    int miscompares = 0;
    int tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    acirq_bank uut (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .core_events(ev), .result_buffer_read(rbr),
        .conv_length(8'h0a), .channel_mode(mode), .individual_irq(ind), .early_irq(early),
        .common_irq(common_irq), .irq(irq));
    acirq_core_model cores (.ref_clk(ref_clk), .start(start), .ch(ch), .pace(pace),
        .conv_length(8'h0a), .core_events(ev), .busy(busy), .ticks(ticks));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // Holds the request until ack is sampled; a bounded wait stands in for a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string m);
        logic [31:0] q;
        wb(1'b0, a, 16'h0000, q);
        chk(q, {16'h0000, e}, m);
    endtask
    // Returns the tick count seen with the early pulse, 0xff when none came
    task automatic convert(input logic [4:0] c, output logic [7:0] at);
        int n;
        at = 8'hff;
        n = 0;
        @(posedge ref_clk);
        ch <= c;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        do begin
            @(negedge ref_clk);
            if (early[c] === 1'b1) at = ticks;
            n++;
        end while (busy && n < 200);
        repeat (3) @(posedge ref_clk);
        if (n >= 200) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic buf_read(input int c);
        @(posedge ref_clk);
        rbr[c] <= 1'b1;
        @(posedge ref_clk);
        rbr <= '0;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        for (int a = 0; a < 'h40; a += 4) rd(a[7:0], 16'h0000, "reset value");
        chk({9'h000, mode}, 32'h0000_0000, "mode after reset");
        $display("reset test done");
    endtask
    task automatic t_regs();
        logic [15:0] msk[12] = '{16'hffff, 16'h001f, 16'h0000, 16'h0000, 16'h555f,
            16'h5555, 16'h0155, 16'hffff, 16'h001f, 16'h0000, 16'h0000, 16'h0007};
        for (int i = 0; i < 12; i++) begin
            wr(8'(i * 4), 16'hffff);
            rd(8'(i * 4), msk[i], "register mask");
        end
        chk({9'h000, mode}, {9'h000, 21'h1f_ffff, 2'h3}, "all modes set");
        wr(8'h10, 16'h0004);
        @(negedge ref_clk);
        chk({mode.signed_output_sel[7:0], mode.differential_sel}, 10'h008, "sign one");
        wr(8'h10, 16'h0002);
        @(negedge ref_clk);
        chk({mode.signed_output_sel[7:0], mode.differential_sel}, 10'h001, "diff zero");
        for (int i = 0; i < 12; i++) wr(8'(i * 4), 16'h0000);
        $display("register test done");
    endtask
    task automatic t_early();
        logic [7:0] at;
        wr(8'h00, 16'h0020);
        for (int s = 0; s < 8; s++) begin
            wr(8'h2c, 16'(s));
            pace <= s[0] ? 2'h1 : 2'h3;
            convert(5'd5, at);
            chk({24'h000000, at}, 32'(10 - LEAD_MIN_PERIODS - s), "early lead");
            rd(8'h08, 16'h0020, "early flag set");
            buf_read(5);
            rd(8'h08, 16'h0000, "early flag cleared");
        end
        wr(8'h04, 16'h0010);
        convert(5'd20, at);
        rd(8'h0c, 16'h0010, "early flag high half");
        buf_read(20);
        wr(8'h00, 16'h0000);
        convert(5'd5, at);
        chk({24'h000000, at}, 32'h0000_00ff, "early while disabled");
        rd(8'h08, 16'h0000, "no flag while disabled");
        buf_read(5);
        $display("early test done");
    endtask
    task automatic t_ready();
        logic [7:0] at;
        wr(8'h34, 16'h0003);
        wr(8'h1c, 16'h0008);
        wr(8'h38, 16'h0002);
        convert(5'd3, at);
        convert(5'd18, at);
        rd(8'h24, 16'h0008, "ready low");
        rd(8'h28, 16'h0004, "ready high");
        chk({ind, common_irq, irq}, {21'h00_0008, 1'b1, 1'b1}, "interrupts");
        rd(8'h30, 16'h0002, "event status");
        wr(8'h38, 16'h0000);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000, "masked interrupt");
        buf_read(3);
        buf_read(18);
        rd(8'h24, 16'h0000, "ready cleared");
        rd(8'h28, 16'h0000, "ready high cleared");
        chk({ind, common_irq}, 32'h0000_0000, "interrupts cleared");
        wr(8'h34, 16'h0003);
        rd(8'h30, 16'h0000, "event cleared");
        $display("ready test done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_regs();
        t_early();
        t_ready();
        wr(8'h00, 16'hffff);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        end_of_test();
    end
endmodule
